// >>> rtl/load_store_engine.v
// Load/store engine: descriptor registers, packet builder, response path
// Operation
// - Arbiter grants free shared TX buffer slots
// - Handoff after last byte, then free slot
// - Check payload completion on each DMA segment
// - Sixteen payload slots plus sixteen plain slots
// - Buffer words are 128 bits wide
// - Pool drains strictly in arrival order
// - Single-segment posted write releases hold after header; multi-segment waits for drain
// - Flow-blocked request flags code and holds
// - One outstanding non-posted request, hold until response
// - Swap response checked inside, never sent
// - Flow check, FIFO check, then DMA read
// - Reads use plain slot, no RX reservation
// - Split long or unaligned requests into packets
// - Release after all segments sent or answered
// - Accept type 13 responses except 0001b
// - Stage response, match by transaction identifier
// - DONE payload to memory; error raises interrupt
// - Four-bit timer matches timecode for timeout
// - Prescaled timecode steps after timeout count
// - Error interrupt; service interrupt only if notify
// - Doorbell retry interrupts and releases, no resend
// - Shut flow: interrupt, code 010b, hold
// - Reset clears command fields, waits idle
`timescale 1ns/1ns
`default_nettype none
`include "lse_defs.vh"
module load_store_engine #(
	parameter [23:0] TIMEOUT_INIT = `TIMEOUT_INIT
)(
	input  wire         clk,
	input  wire         reset_n,
	input  wire         cfgWrite,
	input  wire         cfgRead,
	input  wire [7:0]   cfgAddr,
	input  wire [31:0]  cfgWdata,
	output reg  [31:0]  cfgRdata,
	output reg  [15:0]  flowDest,
	output reg  [1:0]   flowPrio,
	output reg  [1:0]   txPort,
	input  wire         flowOff,
	input  wire         txFifoFree,
	output reg          dmaRdReq,
	output reg  [31:0]  dmaRdAddr,
	output reg  [8:0]   dmaRdLen,
	output reg  [3:0]   dmaRdTag,
	input  wire         dmaRspValid,
	input  wire [3:0]   dmaRspTag,
	input  wire [127:0] dmaRspData,
	input  wire         dmaRspLast,
	output reg          dmaWrValid,
	output reg  [31:0]  dmaWrAddr,
	output reg  [127:0] dmaWrData,
	output wire         txValid,
	output wire [127:0] txData,
	output wire         txLast,
	input  wire         txReady,
	input  wire         rspValid,
	output reg          rspReady,
	input  wire [3:0]   rspFtype,
	input  wire [3:0]   rspTtype,
	input  wire [3:0]   rspStatus,
	input  wire [7:0]   rspTid,
	input  wire [127:0] rspData,
	input  wire         rspLast,
	output reg          irq,
	output reg          errLog
);
	localparam S_IDLE = 4'h0, S_FLOW = 4'h1, S_ALLOC = 4'h2, S_DMA = 4'h3;
	localparam S_FILL = 4'h4, S_HDR = 4'h5, S_RSP = 4'h6, S_DRAIN = 4'h7;
	localparam S_HOLD = 4'h8;

	// Packet length for the next segment of a request
	function [8:0] seg_len;
		input [31:0] a;
		input [12:0] r;
		reg   [12:0] n;
		begin
			if (a[2:0] != 3'h0)
				n = `ALIGN_BYTES - {10'h000, a[2:0]};
			else
				n = `SEG_MAX - {5'h00, a[7:0]};
			if (r < n)
				n = r;
			seg_len = n[8:0];
		end
	endfunction

	function [4:0] words_of;
		input [8:0] len;
		reg   [9:0] s;
		begin
			s = {1'b0, len} + 10'h00F;
			words_of = s[8:4];
		end
	endfunction

	// ----------------------------------------------------------------
	// Descriptor and control state
	// ----------------------------------------------------------------
	reg  [31:0]  remote_q, local_q, curRemote_q, curLocal_q, rxAddr_q;
	reg  [12:0]  count_q, remain_q;
	reg  [20:0]  route_q;
	reg  [3:0]   ftype_q, ttype_q, state_q, flags_q, timer_q;
	reg  [3:0]   prescale_q, pre_q, timecode_q;
	reg  [23:0]  tmoVal_q, tmoCnt_q;
	reg          busy_q, firstSeg_q, tcStep_q;
	reg  [2:0]   code_q;
	reg  [8:0]   segLen_q;
	reg  [7:0]   tid_q;
	reg  [4:0]   slot_q, fillCnt_q;
	reg  [127:0] payMem [0:255];
	reg  [127:0] hdrMem [0:31];
	reg  [4:0]   slotWords [0:31];
	reg  [4:0]   ordQ [0:31];
	reg  [5:0]   wrPtr_q, rdPtr_q;
	reg          drainOn_q;
	reg  [4:0]   drainSlot_q, drainWord_q;
	reg  [3:0]   flagSet;
	reg          take;
	reg  [4:0]   takeIdx;
	wire         payAvail, plainAvail, bufInReady;
	wire [4:0]   payIdx, plainIdx;
	wire [127:0] bufData;
	wire         isPosted = (ftype_q == `FT_SWRITE) ||
		((ftype_q == `FT_WRITE) && (ttype_q == `TT_NWRITE));
	wire         hasPay = (ftype_q == `FT_SWRITE) || (ftype_q == `FT_WRITE);
	wire         isSwap = (ftype_q == `FT_WRITE) && (ttype_q == `TT_SWAP);
	wire         lastSeg = (remain_q == {4'h0, segLen_q});
	wire         swDesc = cfgWrite && !busy_q;
	wire         isrDone = cfgWrite && (cfgAddr == `OFS_STATUS) &&
		cfgWdata[`ST_ISR_DONE];
	wire         rspTake = rspValid && rspReady &&
		(rspFtype == `FT_RESP) && (rspTtype != `TT_MSGRSP);
	wire         rspMine = rspTake && (state_q == S_RSP) &&
		(rspTid == tid_q - 8'h01);
	wire         dmaHit = dmaRspValid && (state_q == S_FILL) &&
		(dmaRspTag == slot_q[3:0]);
	wire         filled = dmaHit && dmaRspLast &&
		(fillCnt_q + 5'h01 == words_of(segLen_q));
	wire         qEmpty = (wrPtr_q == rdPtr_q);
	wire         drainEnd = drainOn_q && bufInReady &&
		(drainWord_q == slotWords[drainSlot_q]);
	wire         tmoHit = tcStep_q && (timecode_q == timer_q);
	// Set wins over the write-one-to-clear
	wire [3:0]   flagsNext = (flags_q & ~((cfgWrite &&
		cfgAddr == `OFS_STATUS) ? cfgWdata[`ST_FLAGS] : 4'h0)) | flagSet;

	// ----------------------------------------------------------------
	// Interrupt condition flags
	// ----------------------------------------------------------------
	always @*
	begin
		flagSet = 4'h0;
		if (state_q == S_FLOW && flowOff)
			flagSet[`FL_FLOW] = 1'b1;
		if (rspMine && rspLast)
		begin
			if (rspStatus == `RS_ERROR || rspStatus == `RS_RETRY)
				flagSet[`FL_ERROR] = 1'b1;
			else if (route_q[`ROUTE_NOTIFY] && lastSeg)
				flagSet[`FL_SERVICE] = 1'b1;
		end
		else if (state_q == S_RSP && tmoHit)
			flagSet[`FL_TIMEOUT] = 1'b1;
	end

	// ----------------------------------------------------------------
	// Register file and request sequencer
	// ----------------------------------------------------------------
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			remote_q   <= 32'h00000000;
			local_q    <= 32'h00000000;
			count_q    <= 13'h0000;
			route_q    <= 21'h000000;
			ftype_q    <= 4'h0;
			ttype_q    <= 4'h0;
			busy_q     <= 1'b0;
			code_q     <= `CC_DONE;
			flags_q    <= 4'h0;
			prescale_q <= 4'h0;
			tmoVal_q   <= TIMEOUT_INIT;
			state_q    <= S_IDLE;
			curRemote_q <= 32'h00000000;
			curLocal_q <= 32'h00000000;
			rxAddr_q   <= 32'h00000000;
			remain_q   <= 13'h0000;
			segLen_q   <= 9'h000;
			tid_q      <= 8'h00;
			slot_q     <= 5'h00;
			fillCnt_q  <= 5'h00;
			timer_q    <= 4'h0;
			firstSeg_q <= 1'b0;
			dmaRdReq   <= 1'b0;
			dmaRdAddr  <= 32'h00000000;
			dmaRdLen   <= 9'h000;
			dmaRdTag   <= 4'h0;
			dmaWrValid <= 1'b0;
			dmaWrAddr  <= 32'h00000000;
			dmaWrData  <= 128'h0;
			rspReady   <= 1'b0;
			errLog     <= 1'b0;
			irq        <= 1'b0;
			cfgRdata   <= 32'h00000000;
			flowDest   <= 16'h0000;
			flowPrio   <= 2'h0;
			txPort     <= 2'h0;
		end
		else
		begin
			rspReady   <= 1'b1;
			dmaRdReq   <= 1'b0;
			dmaWrValid <= 1'b0;
			errLog     <= 1'b0;
			flowDest   <= route_q[15:0];
			flowPrio   <= route_q[`ROUTE_PRIO];
			txPort     <= route_q[`ROUTE_PORT];
			flags_q <= flagsNext;
			irq <= |flagsNext;
			if (cfgWrite && cfgAddr == `OFS_SETTINGS)
				prescale_q <= cfgWdata[`SET_PRESCALE];
			if (cfgWrite && cfgAddr == `OFS_TIMEOUT)
				tmoVal_q <= cfgWdata[23:0];
			if (swDesc)
				case (cfgAddr)
				`OFS_REMOTE: remote_q <= cfgWdata;
				`OFS_LOCAL:  local_q <= cfgWdata;
				`OFS_COUNT:  count_q <= cfgWdata[12:0];
				`OFS_ROUTE:  route_q <= cfgWdata[20:0];
				default:     ;
				endcase
			if (cfgRead)
				case (cfgAddr)
				`OFS_REMOTE:   cfgRdata <= remote_q;
				`OFS_LOCAL:    cfgRdata <= local_q;
				`OFS_COUNT:    cfgRdata <= {19'h00000, count_q};
				`OFS_ROUTE:    cfgRdata <= {11'h000, route_q};
				`OFS_COMMAND:  cfgRdata <= {24'h000000, ttype_q, ftype_q};
				`OFS_STATUS:   cfgRdata <= {24'h000000, flags_q,
					busy_q ? `CC_INVALID : code_q, busy_q};
				`OFS_SETTINGS: cfgRdata <= {28'h0000000, prescale_q};
				`OFS_TIMEOUT:  cfgRdata <= {8'h00, tmoVal_q};
				default:       cfgRdata <= 32'h00000000;
				endcase
			if (rspMine && rspStatus == `RS_DONE && !isSwap &&
				ftype_q == `FT_NREAD)
			begin
				dmaWrValid <= 1'b1;
				dmaWrAddr  <= rxAddr_q;
				dmaWrData  <= rspData;
				rxAddr_q   <= rxAddr_q + 32'h00000010;
			end
			case (state_q)
			S_IDLE:
				if (swDesc && cfgAddr == `OFS_COMMAND)
				begin
					ftype_q     <= cfgWdata[3:0];
					ttype_q     <= cfgWdata[7:4];
					busy_q      <= 1'b1;
					curRemote_q <= remote_q;
					curLocal_q  <= local_q;
					remain_q    <= count_q;
					segLen_q    <= seg_len(remote_q, count_q);
					firstSeg_q  <= 1'b1;
					state_q     <= S_FLOW;
				end
			S_FLOW:
				if (flowOff)
				begin
					code_q  <= `CC_FLOWOFF;
					state_q <= S_HOLD;
				end
				else if (txFifoFree)
					state_q <= S_ALLOC;
			S_ALLOC:
				if (hasPay && payAvail)
				begin
					slot_q  <= payIdx;
					state_q <= S_DMA;
				end
				else if (!hasPay && plainAvail)
				begin
					slot_q  <= plainIdx;
					state_q <= S_HDR;
				end
			S_DMA:
			begin
				dmaRdReq  <= 1'b1;
				dmaRdAddr <= curLocal_q;
				dmaRdLen  <= segLen_q;
				dmaRdTag  <= slot_q[3:0];
				fillCnt_q <= 5'h00;
				state_q   <= S_FILL;
			end
			S_FILL:
				if (dmaHit)
				begin
					fillCnt_q <= fillCnt_q + 5'h01;
					if (filled)
						state_q <= S_HDR;
				end
			S_HDR:
			begin
				tid_q       <= tid_q + 8'h01;
				timer_q     <= timecode_q;
				rxAddr_q    <= curLocal_q;
				firstSeg_q  <= 1'b0;
				if (isPosted)
				begin
					curRemote_q <= curRemote_q + {23'h000000, segLen_q};
					curLocal_q  <= curLocal_q + {23'h000000, segLen_q};
					remain_q    <= remain_q - {4'h0, segLen_q};
					segLen_q    <= seg_len(curRemote_q +
						{23'h000000, segLen_q},
						remain_q - {4'h0, segLen_q});
					if (!lastSeg)
						state_q <= S_FLOW;
					else if (firstSeg_q)
					begin
						busy_q  <= 1'b0;
						code_q  <= `CC_DONE;
						state_q <= S_IDLE;
					end
					else
						state_q <= S_DRAIN;
				end
				else
					state_q <= S_RSP;
			end
			S_RSP:
				if (rspMine && rspLast)
				begin
					if (rspStatus == `RS_ERROR || rspStatus == `RS_RETRY)
					begin
						code_q  <= (rspStatus == `RS_ERROR) ?
							`CC_ERROR : `CC_RETRY;
						busy_q  <= 1'b0;
						state_q <= S_IDLE;
					end
					else if (!lastSeg)
					begin
						curRemote_q <= curRemote_q + {23'h000000, segLen_q};
						curLocal_q  <= curLocal_q + {23'h000000, segLen_q};
						remain_q    <= remain_q - {4'h0, segLen_q};
						segLen_q    <= seg_len(curRemote_q +
							{23'h000000, segLen_q},
							remain_q - {4'h0, segLen_q});
						state_q     <= S_FLOW;
					end
					else
					begin
						code_q  <= (isSwap && rspData[63:0] != 64'h0) ?
							`CC_SWAPREJ : `CC_DONE;
						busy_q  <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				else if (tmoHit)
				begin
					code_q  <= `CC_TIMEOUT;
					errLog  <= 1'b1;
					busy_q  <= 1'b0;
					state_q <= S_IDLE;
				end
			S_DRAIN:
				if (qEmpty && !drainOn_q)
				begin
					code_q  <= `CC_DONE;
					busy_q  <= 1'b0;
					state_q <= S_IDLE;
				end
			S_HOLD:
				if (isrDone)
				begin
					busy_q  <= 1'b0;
					state_q <= S_IDLE;
				end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Timecode generator
	// ----------------------------------------------------------------
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pre_q      <= 4'h0;
			tmoCnt_q   <= 24'h000000;
			timecode_q <= 4'h0;
			tcStep_q   <= 1'b0;
		end
		else
		begin
			tcStep_q <= 1'b0;
			if (pre_q >= prescale_q)
			begin
				pre_q <= 4'h0;
				if (tmoCnt_q >= tmoVal_q)
				begin
					tmoCnt_q   <= 24'h000000;
					timecode_q <= timecode_q + 4'h1;
					tcStep_q   <= 1'b1;
				end
				else
					tmoCnt_q <= tmoCnt_q + 24'h000001;
			end
			else
				pre_q <= pre_q + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Shared TX buffer pool and in-order drain
	// ----------------------------------------------------------------
	always @*
	begin
		take    = (state_q == S_ALLOC) &&
			(hasPay ? payAvail : plainAvail);
		takeIdx = hasPay ? payIdx : plainIdx;
	end

	always @(posedge clk)
	begin
		if (dmaHit)
			payMem[{slot_q[3:0], fillCnt_q[3:0]}] <= dmaRspData;
		if (state_q == S_HDR)
		begin
			hdrMem[slot_q] <= {curRemote_q, route_q[15:0],
				route_q[`ROUTE_PRIO], route_q[`ROUTE_PORT], ftype_q,
				ttype_q, tid_q, segLen_q, curRemote_q[2], 50'h0};
			slotWords[slot_q] <= hasPay ? words_of(segLen_q) : 5'h00;
			ordQ[wrPtr_q[4:0]] <= slot_q;
		end
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrPtr_q     <= 6'h00;
			rdPtr_q     <= 6'h00;
			drainOn_q   <= 1'b0;
			drainSlot_q <= 5'h00;
			drainWord_q <= 5'h00;
		end
		else
		begin
			if (state_q == S_HDR)
				wrPtr_q <= wrPtr_q + 6'h01;
			if (!drainOn_q && !qEmpty)
			begin
				drainOn_q   <= 1'b1;
				drainSlot_q <= ordQ[rdPtr_q[4:0]];
				drainWord_q <= 5'h00;
				rdPtr_q     <= rdPtr_q + 6'h01;
			end
			else if (drainOn_q && bufInReady)
			begin
				drainWord_q <= drainWord_q + 5'h01;
				if (drainEnd)
					drainOn_q <= 1'b0;
			end
		end
	end

	assign bufData = (drainWord_q == 5'h00) ? hdrMem[drainSlot_q] :
		payMem[{drainSlot_q[3:0], drainWord_q[3:0] - 4'h1}];

	slot_pool u_pool (
		.clk        (clk),
		.reset_n    (reset_n),
		.take       (take),
		.takeIdx    (takeIdx),
		.giveBack   (drainEnd),
		.releaseIdx (drainSlot_q),
		.payAvail   (payAvail),
		.payIdx     (payIdx),
		.plainAvail (plainAvail),
		.plainIdx   (plainIdx)
	);

	skid_buffer #(
		.WIDTH (129)
	) u_out (
		.clk      (clk),
		.reset_n  (reset_n),
		.inValid  (drainOn_q),
		.inReady  (bufInReady),
		.inData   ({drainEnd, bufData}),
		.outValid (txValid),
		.outReady (txReady),
		.outData  ({txLast, txData})
	);
endmodule
`default_nettype wire

// >>> rtl/lse_defs.vh
// Offsets, field codes and timing constants of the load/store engine
`ifndef LSE_DEFS_VH
`define LSE_DEFS_VH
`define OFS_REMOTE   8'h00
`define OFS_LOCAL    8'h04
`define OFS_COUNT    8'h08
`define OFS_ROUTE    8'h0C
`define OFS_COMMAND  8'h10
`define OFS_STATUS   8'h14
`define OFS_SETTINGS 8'h20
`define OFS_TIMEOUT  8'h24
`define ROUTE_PRIO   17:16
`define ROUTE_PORT   19:18
`define ROUTE_NOTIFY 20
`define ST_ISR_DONE  0
`define ST_FLAGS     7:4
`define SET_PRESCALE 3:0
`define CC_DONE      3'h0
`define CC_TIMEOUT   3'h1
`define CC_FLOWOFF   3'h2
`define CC_ERROR     3'h3
`define CC_RETRY     3'h4
`define CC_SWAPREJ   3'h5
`define CC_INVALID   3'h7
`define FL_ERROR     0
`define FL_SERVICE   1
`define FL_FLOW      2
`define FL_TIMEOUT   3
`define RS_DONE      4'h0
`define RS_RETRY     4'h3
`define RS_ERROR     4'h7
`define FT_NREAD     4'h2
`define FT_WRITE     4'h5
`define FT_SWRITE    4'h6
`define FT_DBELL     4'hA
`define FT_RESP      4'hD
`define TT_NWRITE    4'h4
`define TT_SWAP      4'hE
`define TT_MSGRSP    4'h1
`define SEG_MAX      13'h100
`define ALIGN_BYTES  13'h008
`define TIMEOUT_INIT 24'hFFFFFF
`endif

// >>> rtl/skid_buffer.v
// Two-entry buffer between the drain sequencer and the TX FIFO port
`timescale 1ns/1ns
`default_nettype none
module skid_buffer #(
	parameter WIDTH = 129
)(
	input  wire             clk,
	input  wire             reset_n,
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	output reg              outValid,
	input  wire             outReady,
	output reg  [WIDTH-1:0] outData
);
	reg             spareValid;
	reg [WIDTH-1:0] spareData;

	assign inReady = !spareValid;

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			outValid   <= 1'b0;
			outData    <= {WIDTH{1'b0}};
			spareValid <= 1'b0;
			spareData  <= {WIDTH{1'b0}};
		end
		else if (!outValid || outReady)
		begin
			// Head empties or moves on: refill from spare first
			if (spareValid)
			begin
				outValid   <= 1'b1;
				outData    <= spareData;
				spareValid <= 1'b0;
			end
			else
			begin
				outValid <= inValid;
				outData  <= inData;
			end
		end
		else if (inValid && !spareValid)
		begin
			spareValid <= 1'b1;
			spareData  <= inData;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/slot_pool.v
// Free-slot tracker: 16 payload slots (0-15) and 16 plain slots (16-31)
`timescale 1ns/1ns
`default_nettype none
module slot_pool (
	input  wire       clk,
	input  wire       reset_n,
	input  wire       take,
	input  wire [4:0] takeIdx,
	input  wire       giveBack,
	input  wire [4:0] releaseIdx,
	output reg        payAvail,
	output reg  [4:0] payIdx,
	output reg        plainAvail,
	output reg  [4:0] plainIdx
);
	reg [31:0] free_q;
	integer    i;

	always @*
	begin
		payAvail   = 1'b0;
		payIdx     = 5'h00;
		plainAvail = 1'b0;
		plainIdx   = 5'h10;
		for (i = 15; i >= 0; i = i - 1)
		begin
			if (free_q[i])
			begin
				payAvail = 1'b1;
				payIdx   = i[4:0];
			end
			if (free_q[i + 16])
			begin
				plainAvail = 1'b1;
				plainIdx   = i[4:0] + 5'h10;
			end
		end
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			free_q <= 32'hFFFFFFFF;
		else
		begin
			if (giveBack)
				free_q[releaseIdx] <= 1'b1;
			if (take)
				free_q[takeIdx] <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/lse_checker_asserts.sv
// Port checks for the load/store engine
`timescale 1ns/1ns
`default_nettype none
module lse_checker (
	input wire logic         clk,
	input wire logic         reset_n,
	input wire logic         cfgRead,
	input wire logic [31:0]  cfgRdata,
	input wire logic         dmaRdReq,
	input wire logic [31:0]  dmaRdAddr,
	input wire logic [8:0]   dmaRdLen,
	input wire logic [3:0]   dmaRdTag,
	input wire logic         txValid,
	input wire logic [127:0] txData,
	input wire logic         txLast,
	input wire logic         txReady,
	input wire logic         cfgWrite,
	input wire logic         rspReady,
	input wire logic         irq,
	input wire logic         errLog
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence txStall;
		txValid && !txReady;
	endsequence
	rdy_after_reset_a: assert property ($past(reset_n) |-> rspReady)
		else $error("response ready low after reset");
	rd_pulse_a: assert property (dmaRdReq |=> !dmaRdReq)
		else $error("read request longer than one cycle");
	rd_len_a: assert property (dmaRdReq |->
		dmaRdLen >= 9'h001 && dmaRdLen <= 9'h100)
		else $error("read length out of range");
	rd_hold_a: assert property (!dmaRdReq |->
		$stable({dmaRdAddr, dmaRdLen, dmaRdTag}))
		else $error("read request fields moved");
	tx_hold_a: assert property (txStall |=>
		txValid && $stable({txData, txLast}))
		else $error("stalled word changed");
	cfg_stand_a: assert property (!$past(cfgRead) |-> $stable(cfgRdata))
		else $error("read data changed without read");
	irq_hold_a: assert property (irq && !cfgWrite |=> irq)
		else $error("interrupt dropped without service");
	err_pulse_a: assert property (errLog |=> !errLog)
		else $error("error log longer than one cycle");
	err_irq_a: assert property (errLog |-> ##[0:1] irq)
		else $error("timeout without interrupt");
endmodule
bind load_store_engine lse_checker u_lse_checker (.clk(clk), .reset_n(reset_n),
	.cfgRead(cfgRead), .cfgRdata(cfgRdata), .dmaRdReq(dmaRdReq),
	.dmaRdAddr(dmaRdAddr), .dmaRdLen(dmaRdLen), .dmaRdTag(dmaRdTag),
	.txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
	.cfgWrite(cfgWrite), .rspReady(rspReady), .irq(irq), .errLog(errLog));
`default_nettype wire

// >>> tb/lse_far_model.sv
// DMA responder and stalling TX FIFO sink
`timescale 1ns/1ns
`default_nettype none
module lse_far_model (
	input wire logic         clk,
	input wire logic         reset_n,
	input wire logic         dmaRdReq,
	input wire logic [8:0]   dmaRdLen,
	input wire logic [3:0]   dmaRdTag,
	output logic             dmaRspValid,
	output logic [3:0]       dmaRspTag,
	output logic [127:0]     dmaRspData,
	output logic             dmaRspLast,
	input wire logic         txValid,
	input wire logic         txLast,
	output logic             txReady,
	output logic [15:0]      reqCount,
	output logic [15:0]      wordCount,
	output logic [15:0]      pktCount
);
	logic [4:0] left;
	always @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			{dmaRspValid, dmaRspTag, dmaRspLast, txReady, left} <= 12'h000;
			dmaRspData <= 128'h0;
			{reqCount, wordCount, pktCount} <= 48'h0;
		end
		else
		begin
			txReady <= ~txReady;
			if (txValid && txReady)
			begin
				wordCount <= wordCount + 16'h0001;
				pktCount <= pktCount + {15'h0, txLast};
			end
			if (dmaRdReq)
			begin
				left <= 5'(({1'b0, dmaRdLen} + 10'h00F) >> 4);
				dmaRspTag <= dmaRdTag;
				reqCount <= reqCount + 16'h0001;
			end
			dmaRspValid <= !dmaRdReq && left != 5'h00;
			dmaRspLast <= !dmaRdReq && left == 5'h01;
			if (!dmaRdReq && left != 5'h00)
				left <= left - 5'h01;
			dmaRspData <= (left != 5'h00) ? {8{11'h000, left}} : ~dmaRspData;
		end
endmodule
`default_nettype wire

// >>> tb/load_store_engine_tb.sv
// Self-checking bench for the load/store engine
`timescale 1ns/1ns
`default_nettype none
module load_store_engine_tb;
	logic         clk = 1'b0, reset_n = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0;
	logic         flowOff = 1'b0, txFifoFree = 1'b1, rspValid = 1'b0;
	logic         rspLast = 1'b0, dmaRspValid, dmaRspLast, dmaRdReq, dmaWrValid;
	logic         txValid, txLast, txReady, rspReady, irq, errLog;
	logic [7:0]   cfgAddr = 8'h00, rspTid = 8'h00, tid;
	logic [31:0]  cfgWdata = 32'h0, cfgRdata, dmaRdAddr, dmaWrAddr, s;
	logic [31:0]  wrAddr = 32'h0;
	logic [3:0]   rspFtype = 4'h0, rspTtype = 4'h0, rspStatus = 4'h0;
	logic [3:0]   dmaRdTag, dmaRspTag;
	logic [127:0] rspData = 128'h0, dmaRspData, dmaWrData, txData;
	logic [15:0]  flowDest, reqCount, wordCount, pktCount, p0, w0, q0;
	logic [15:0]  wrSeen = 16'h0;
	logic [1:0]   flowPrio, txPort;
	logic [8:0]   dmaRdLen;
	logic [71:0]  regRows [0:2] = '{{8'h20, 32'h1, 32'h1},
		{8'h24, 32'h9, 32'h9}, {8'h30, 32'h5, 32'h0}};
	logic [63:0]  segRows [0:2] = '{{32'h0, 16'h20, 8'h1, 8'h3},
		{32'h0, 16'h12C, 8'h2, 8'h15}, {32'h4, 16'h10, 8'h2, 8'h4}};
	int errors = 0, check_count = 0, i, n;
	always #50 clk = ~clk;
	always @(posedge clk)
		if (dmaWrValid)
		begin
			wrSeen <= wrSeen + 16'h0001;
			wrAddr <= {dmaWrData[15:0], dmaWrAddr[15:0]};
		end
	load_store_engine #(.TIMEOUT_INIT(24'h000009)) u_load_store_engine (
		.clk(clk), .reset_n(reset_n), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
		.cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
		.flowDest(flowDest), .flowPrio(flowPrio), .txPort(txPort),
		.flowOff(flowOff), .txFifoFree(txFifoFree), .dmaRdReq(dmaRdReq),
		.dmaRdAddr(dmaRdAddr), .dmaRdLen(dmaRdLen), .dmaRdTag(dmaRdTag),
		.dmaRspValid(dmaRspValid), .dmaRspTag(dmaRspTag),
		.dmaRspData(dmaRspData), .dmaRspLast(dmaRspLast),
		.dmaWrValid(dmaWrValid), .dmaWrAddr(dmaWrAddr), .dmaWrData(dmaWrData),
		.txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
		.rspValid(rspValid), .rspReady(rspReady), .rspFtype(rspFtype),
		.rspTtype(rspTtype), .rspStatus(rspStatus), .rspTid(rspTid),
		.rspData(rspData), .rspLast(rspLast), .irq(irq), .errLog(errLog));
	lse_far_model u_lse_far_model (.clk(clk), .reset_n(reset_n),
		.dmaRdReq(dmaRdReq), .dmaRdLen(dmaRdLen), .dmaRdTag(dmaRdTag),
		.dmaRspValid(dmaRspValid), .dmaRspTag(dmaRspTag),
		.dmaRspData(dmaRspData), .dmaRspLast(dmaRspLast), .txValid(txValid),
		.txLast(txLast), .txReady(txReady), .reqCount(reqCount),
		.wordCount(wordCount), .pktCount(pktCount));
	task give_verdict;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cfgWrite <= 1'b1;
		cfgAddr <= a;
		cfgWdata <= d;
		@(posedge clk);
		cfgWrite <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		cfgRead <= 1'b1;
		cfgAddr <= a;
		@(posedge clk);
		cfgRead <= 1'b0;
		@(posedge clk);
		s = cfgRdata;
	endtask
	task go(input logic [31:0] rem, input logic [15:0] cnt,
		input logic [31:0] route, input logic [7:0] cmd);
		p0 = pktCount;
		q0 = reqCount;
		w0 = wordCount;
		wr(8'h00, rem);
		wr(8'h04, 32'h0000_1000);
		wr(8'h08, {16'h0, cnt});
		wr(8'h0C, route);
		wr(8'h10, {24'h0, cmd});
	endtask
	task idle(input logic [7:0] exp);
		s = 32'h1;
		for (n = 0; n < 400 && s[0] !== 1'b0; n++)
			rd(8'h14);
		chk(s, {24'h0, exp});
		if (s[0] !== 1'b0)
			give_verdict;
	endtask
	task waitPkt(input logic [15:0] target);
		for (n = 0; n < 600 && pktCount !== target; n++)
			@(posedge clk);
		chk({16'h0, pktCount}, {16'h0, target});
		if (pktCount !== target)
			give_verdict;
		tid = 8'(pktCount - 16'h0001);
	endtask
	task rsp(input logic [3:0] st, input logic [3:0] tt, input logic [127:0] d);
		@(posedge clk);
		{rspValid, rspLast, rspFtype, rspTtype, rspStatus} <= {2'h3, 4'hD, tt, st};
		rspTid <= tid;
		rspData <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rspReady !== 1'b1 && n < 50);
		chk({31'h0, rspReady}, 32'h1);
		if (rspReady !== 1'b1)
			give_verdict;
		{rspValid, rspLast} <= 2'h0;
		rspData <= ~d;
	endtask
	task waitSig(input int which);
		for (n = 0; n < 1000 && (which ? errLog : irq) !== 1'b1; n++)
			@(posedge clk);
		chk({31'h0, (which ? errLog : irq)}, 32'h1);
		if ((which ? errLog : irq) !== 1'b1)
			give_verdict;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk({28'h0, rspReady, irq, txValid, dmaRdReq}, 32'h8);
		for (i = 0; i < 3; i++)
		begin
			wr(regRows[i][71:64], regRows[i][63:32]);
			rd(regRows[i][71:64]);
			chk(s, regRows[i][31:0]);
		end
		txFifoFree <= 1'b0;
		go(32'h0, 16'h10, 32'h0009_1234, 8'h06);
		repeat (12) @(posedge clk);
		chk({16'h0, reqCount}, {16'h0, q0});
		chk({12'h0, flowDest, flowPrio, txPort}, 32'h0001_2346);
		txFifoFree <= 1'b1;
		idle(8'h00);
		waitPkt(p0 + 16'h1);
		for (i = 0; i < 3; i++)
		begin
			go(segRows[i][63:32], segRows[i][31:16], 32'h0, 8'h06);
			idle(8'h00);
			waitPkt(p0 + {8'h0, segRows[i][15:8]});
			chk({16'h0, wordCount - w0}, {24'h0, segRows[i][7:0]});
			chk({16'h0, reqCount - q0}, {24'h0, segRows[i][15:8]});
		end
		flowOff <= 1'b1;
		go(32'h0, 16'h10, 32'h0, 8'h06);
		waitSig(0);
		rd(8'h14);
		chk(s, 32'h4F);
		flowOff <= 1'b0;
		wr(8'h14, 32'hF1);
		idle(8'h04);
		chk({31'h0, irq}, 32'h0);
		go(32'h0, 16'h10, 32'h0010_0000, 8'h42);
		waitPkt(p0 + 16'h1);
		chk({16'h0, reqCount}, {16'h0, q0});
		rsp(4'h0, 4'h1, 128'h0);
		rd(8'h14);
		chk(s & 32'hF, 32'hF);
		rsp(4'h0, 4'h8, 128'h5);
		idle(8'h20);
		chk({wrSeen, wrAddr[15:0]}, 32'h0001_1000);
		chk(wrAddr, 32'h0005_1000);
		wr(8'h14, 32'hF0);
		go(32'h0, 16'h08, 32'h0, 8'h42);
		waitPkt(p0 + 16'h1);
		rsp(4'h7, 4'h8, 128'h0);
		idle(8'h16);
		repeat (20) @(posedge clk);
		chk({16'h0, pktCount}, {16'h0, p0 + 16'h1});
		chk({31'h0, irq}, 32'h1);
		wr(8'h14, 32'hF0);
		go(32'h0, 16'h00, 32'h0, 8'h0A);
		waitPkt(p0 + 16'h1);
		rsp(4'h3, 4'h0, 128'h0);
		idle(8'h18);
		wr(8'h14, 32'hF0);
		go(32'h0, 16'h08, 32'h0, 8'hE5);
		waitPkt(p0 + 16'h1);
		rsp(4'h0, 4'h8, 128'h7);
		idle(8'h0A);
		chk({16'h0, wrSeen}, 32'h1);
		go(32'h0, 16'h08, 32'h0, 8'h42);
		waitPkt(p0 + 16'h1);
		waitSig(1);
		chk({31'h0, errLog}, 32'h1);
		idle(8'h82);
		give_verdict;
	end
endmodule
`default_nettype wire
